// ===== design/opac_defs.vh
// Register offsets, field positions and reset values of the output port block
`ifndef OPAC_DEFS_VH
`define OPAC_DEFS_VH

// ============================================================
// Register offsets
`define OPAC_ADDR_W          4
`define OPAC_OFS_AUX_CTRL    4'h4
`define OPAC_OFS_IN_CHANGE   4'h4
`define OPAC_OFS_INT_STATUS  4'h5
`define OPAC_OFS_INT_MASK    4'h6
`define OPAC_OFS_OUT_SELECT  4'hD
`define OPAC_OFS_BIT_SETTER  4'hE
`define OPAC_OFS_BIT_CLEARER 4'hF
`define OPAC_OFS_LATCH_VIEW  4'hC

// ============================================================
// Field positions
`define OPAC_AUX_BAUD_SET    7
`define OPAC_AUX_CT_HI       6
`define OPAC_AUX_CT_LO       4
`define OPAC_AUX_TIMER_BIT   6
`define OPAC_ISR_IN_CHANGE   7
`define OPAC_ISR_CT_READY    3

// ============================================================
// Reset values and timing counts
`define OPAC_RST_BYTE        8'h00
`define OPAC_PRESCALE_DIV    16
`define OPAC_CT_RELOAD       16'h0010

`endif

// ===== design/opac_port.v
// Output latch, auxiliary control, input change detection and interrupt logic
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "opac_defs.vh"
// ============================================================
// Function
// [R1] Writing the setter register forces latch bits high where written bits are one.
// [R2] Writing the clearer register forces latch bits low where written bits are one.
// [R3] Each output pin drives the inverse of its latch bit.
// [R4] Auxiliary bit 7 picks one of two baud rate sets for both channels.
// [R5] Auxiliary codes 000-011 select counter mode with four listed clock sources.
// [R6] Auxiliary codes 100-111 select timer mode with four listed clock sources.
// [R7] Timer mode yields a square wave, not a single terminal count event.
// [R8] Auxiliary bits 3 to 0 enable change interrupts for inputs 3 to 0.
// [R9] An enabled input change sets interrupt status bit 7.
// [R10] Status bit 7 raises the interrupt only while mask bit 7 is one.
// [R11] A change on a disabled input leaves status bit 7 untouched.
// [R12] Output select register may switch pins 7 to 2 to other signals.
// [R13] Inputs set change flags; reading the change register clears them and bit 7.
// [R14] Active low interrupt asserts when any status bit and its mask bit are one.
module opac_port #(
    parameter CT_DIV = `OPAC_PRESCALE_DIV
) (
    input  wire        core_clk_in,
    input  wire        nrst_in,
    input  wire [3:0]  addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [7:0]  rdata_out,
    input  wire [3:0]  general_input_pins_in,
    input  wire        chan_a_tx_bit_clock_in,
    input  wire        chan_b_tx_bit_clock_in,
    input  wire        crystal_clock_input_in,
    input  wire [6:0]  other_status_in,
    input  wire [5:0]  alt_pin_src_in,
    output reg  [7:0]  general_output_pins_out,
    output reg  [7:0]  general_output_oe_out,
    output reg         baud_set_sel_out,
    output reg         ct_output_out,
    output reg         interrupt_out_n_out
);

// ============================================================
// Register file
reg  [7:0]  output_latch_q;
reg  [7:0]  auxiliary_control_q;
reg  [7:0]  interrupt_mask_q;
reg  [7:0]  output_select_config_q;
reg  [3:0]  cos_flag_q;
reg         in_change_q;
reg         ct_ready_q;

// Strobes decode straight from the bus; unmapped offsets fall through
wire        wr_set   = wr_in && (addr_in == `OPAC_OFS_BIT_SETTER);
wire        wr_clr   = wr_in && (addr_in == `OPAC_OFS_BIT_CLEARER);
wire        wr_aux   = wr_in && (addr_in == `OPAC_OFS_AUX_CTRL);
wire        wr_mask  = wr_in && (addr_in == `OPAC_OFS_INT_MASK);
wire        wr_osel  = wr_in && (addr_in == `OPAC_OFS_OUT_SELECT);
wire        rd_chg   = rd_in && (addr_in == `OPAC_OFS_IN_CHANGE);
wire        wr_isr   = wr_in && (addr_in == `OPAC_OFS_INT_STATUS);

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        output_latch_q <= `OPAC_RST_BYTE;
    end else begin
        // Both may never coincide: strobes address one register at a time
        if (wr_set) begin
            output_latch_q <= output_latch_q | wdata_in;   // see [R1]
        end else if (wr_clr) begin
            output_latch_q <= output_latch_q & ~wdata_in;  // see [R2]
        end
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        auxiliary_control_q    <= `OPAC_RST_BYTE;
        interrupt_mask_q       <= `OPAC_RST_BYTE;
        output_select_config_q <= `OPAC_RST_BYTE;
    end else begin
        if (wr_aux) begin
            auxiliary_control_q <= wdata_in;
        end
        if (wr_mask) begin
            interrupt_mask_q <= wdata_in;
        end
        if (wr_osel) begin
            output_select_config_q <= wdata_in;
        end
    end
end

// ============================================================
// Input synchronisers, three stages, change once stages two and three agree
reg  [3:0]  ip_s1_q;
reg  [3:0]  ip_s2_q;
reg  [3:0]  ip_s3_q;
reg  [3:0]  ip_stable_q;

reg  [2:0]  clk_s1_q;
reg  [2:0]  clk_s2_q;
reg  [2:0]  clk_s3_q;
reg  [2:0]  clk_stable_q;
wire [2:0]  clk_raw = {crystal_clock_input_in, chan_b_tx_bit_clock_in,
                       chan_a_tx_bit_clock_in};
wire [3:0]  ip_agree = ~(ip_s2_q ^ ip_s3_q);
wire [2:0]  clk_agree = ~(clk_s2_q ^ clk_s3_q);
wire [3:0]  ip_next = (ip_agree & ip_s3_q) | (~ip_agree & ip_stable_q);
wire [3:0]  ip_change = ip_next ^ ip_stable_q;
wire [2:0]  clk_next = (clk_agree & clk_s3_q) | (~clk_agree & clk_stable_q);
wire [2:0]  clk_rise = clk_next & ~clk_stable_q;

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ip_s1_q     <= 4'h0;
        ip_s2_q     <= 4'h0;
        ip_s3_q     <= 4'h0;
        ip_stable_q <= 4'h0;
    end else begin
        ip_s1_q     <= general_input_pins_in;
        ip_s2_q     <= ip_s1_q;
        ip_s3_q     <= ip_s2_q;
        ip_stable_q <= ip_next;
    end
end

// Clock inputs are level sampled, so they must run well below a quarter of the core rate
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        clk_s1_q     <= 3'h0;
        clk_s2_q     <= 3'h0;
        clk_s3_q     <= 3'h0;
        clk_stable_q <= 3'h0;
    end else begin
        clk_s1_q     <= clk_raw;
        clk_s2_q     <= clk_s1_q;
        clk_s3_q     <= clk_s2_q;
        clk_stable_q <= clk_next;
    end
end

// ============================================================
// Change flags and input change status; a new event wins over the read clear
wire        cos_enabled = |(ip_change & auxiliary_control_q[3:0]);  // see [R8] [R11]

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        cos_flag_q <= 4'h0;
    end else begin
        cos_flag_q <= (rd_chg ? 4'h0 : cos_flag_q) | ip_change;  // see [R13]
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        in_change_q <= 1'b0;
    end else if (cos_enabled) begin
        in_change_q <= 1'b1;                                     // see [R9]
    end else if (rd_chg) begin
        in_change_q <= 1'b0;                                     // see [R13]
    end
end

// ============================================================
// Counter/timer clock source and mode
wire [2:0]  ct_code  = auxiliary_control_q[`OPAC_AUX_CT_HI:`OPAC_AUX_CT_LO];
wire        ct_timer = ct_code[2];
reg  [3:0]  ip2_pre_q;
reg  [3:0]  xtal_pre_q;
reg         ct_tick;

wire        ip2_rise = ip_next[2] & ~ip_stable_q[2];
wire        ip2_div  = ip2_rise && ({28'h0000000, ip2_pre_q} == CT_DIV - 1);
wire        xtal_div = clk_rise[2] && ({28'h0000000, xtal_pre_q} == CT_DIV - 1);

// Prescalers count source edges, not core cycles, so the divide is exact
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ip2_pre_q <= 4'h0;
    end else if (ip2_rise) begin
        ip2_pre_q <= ip2_div ? 4'h0 : ip2_pre_q + 4'h1;
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        xtal_pre_q <= 4'h0;
    end else if (clk_rise[2]) begin
        xtal_pre_q <= xtal_div ? 4'h0 : xtal_pre_q + 4'h1;
    end
end

always @* begin
    case (ct_code)
        3'h0: ct_tick = ip2_rise;      // see [R5]
        3'h1: ct_tick = clk_rise[0];   // see [R5]
        3'h2: ct_tick = clk_rise[1];   // see [R5]
        3'h3: ct_tick = xtal_div;      // see [R5]
        3'h4: ct_tick = ip2_rise;      // see [R6]
        3'h5: ct_tick = ip2_div;       // see [R6]
        3'h6: ct_tick = clk_rise[2];   // see [R6]
        3'h7: ct_tick = xtal_div;      // see [R6]
        default: ct_tick = 1'b0;
    endcase
end

// Counter keeps a fixed reload; the preload registers are outside this block
reg  [15:0] ct_count_q;
reg         ct_wave_q;
reg         ct_done_q;
wire        ct_zero = (ct_count_q == 16'h0000);

// Timer reloads at zero, counter parks at zero until the next control write
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ct_count_q <= `OPAC_CT_RELOAD;
    end else if (wr_aux) begin
        ct_count_q <= `OPAC_CT_RELOAD;
    end else if (ct_tick && !ct_zero) begin
        ct_count_q <= ct_count_q - 16'h0001;
    end else if (ct_tick && ct_timer) begin
        ct_count_q <= `OPAC_CT_RELOAD;
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ct_wave_q <= 1'b1;
    end else if (wr_aux) begin
        ct_wave_q <= 1'b1;
    end else if (ct_tick && ct_zero && ct_timer) begin
        ct_wave_q <= ~ct_wave_q;                                 // see [R7]
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ct_done_q <= 1'b0;
    end else if (wr_aux) begin
        ct_done_q <= 1'b0;
    end else if (ct_tick && ct_zero && !ct_timer) begin
        ct_done_q <= 1'b1;                                       // see [R5]
    end
end

// A terminal count in the same cycle as a software clear keeps the flag set
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ct_ready_q <= 1'b0;
    end else if (ct_tick && ct_zero && (!ct_timer || !ct_wave_q)) begin
        ct_ready_q <= 1'b1;
    end else if (wr_isr && wdata_in[`OPAC_ISR_CT_READY]) begin
        ct_ready_q <= 1'b0;
    end
end

// ============================================================
// Interrupt status and pins
// Bit 3 is the local counter ready flag and bit 7 the local input change status; the other lanes come from the channels
wire [7:0]  int_status = {in_change_q,
                          other_status_in[6:4],
                          ct_ready_q,
                          other_status_in[2:0]};
wire        ct_pin = ct_timer ? ct_wave_q : ~ct_done_q;
reg  [7:0]  pin_d;
reg  [7:0]  oe_d;

always @* begin
    pin_d = ~output_latch_q;                                     // see [R3]
    oe_d  = 8'hFF;
    // Interrupt style selections behave as open drain: drive low only
    if (output_select_config_q[7]) begin
        pin_d[7] = 1'b0;
        oe_d[7]  = int_status[4];                                // see [R12]
    end
    if (output_select_config_q[6]) begin
        pin_d[6] = 1'b0;
        oe_d[6]  = int_status[0];                                // see [R12]
    end
    if (output_select_config_q[5]) begin
        pin_d[5] = 1'b0;
        oe_d[5]  = int_status[5];                                // see [R12]
    end
    if (output_select_config_q[4]) begin
        pin_d[4] = 1'b0;
        oe_d[4]  = int_status[1];                                // see [R12]
    end
    case (output_select_config_q[3:2])
        2'h1: begin
            pin_d[3] = 1'b0;
            oe_d[3]  = ~ct_pin;                                  // see [R12]
        end
        2'h2: pin_d[3] = alt_pin_src_in[0];
        2'h3: pin_d[3] = alt_pin_src_in[1];
        default: pin_d[3] = ~output_latch_q[3];
    endcase
    case (output_select_config_q[1:0])
        2'h1: pin_d[2] = alt_pin_src_in[2];
        2'h2: pin_d[2] = alt_pin_src_in[3];
        2'h3: pin_d[2] = alt_pin_src_in[4];
        default: pin_d[2] = ~output_latch_q[2];
    endcase
end

// ============================================================
// Read data and registered outputs
reg  [7:0]  rdata_d;

always @* begin
    rdata_d = 8'h00;
    if (rd_in) begin
        case (addr_in)
            `OPAC_OFS_IN_CHANGE:  rdata_d = {cos_flag_q, ip_stable_q};
            `OPAC_OFS_INT_STATUS: rdata_d = int_status;
            `OPAC_OFS_LATCH_VIEW: rdata_d = output_latch_q;
            default:              rdata_d = 8'h00;
        endcase
    end
end

// Pins and enables register together so an open drain lane never glitches
always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        rdata_out               <= 8'h00;
        general_output_pins_out <= 8'hFF;
        general_output_oe_out   <= 8'hFF;
    end else begin
        rdata_out               <= rdata_d;
        general_output_pins_out <= pin_d;
        general_output_oe_out   <= oe_d;
    end
end

always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        baud_set_sel_out    <= 1'b0;
        ct_output_out       <= 1'b1;
        interrupt_out_n_out <= 1'b1;
    end else begin
        baud_set_sel_out    <= auxiliary_control_q[`OPAC_AUX_BAUD_SET]; // see [R4]
        ct_output_out       <= ct_pin;
        // Bit 7 masking is one lane of the general mask gate
        interrupt_out_n_out <= ~|(int_status & interrupt_mask_q);  // see [R10] [R14]
    end
end

endmodule

// ===== test/opac_port_assertions.sv
// Port checker of the output port block
`timescale 1ns/10ps
// ============================================================
// Checker
module opac_port_assertions (
    input wire       core_clk_in,
    input wire       nrst_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire       wr_in,
    input wire       rd_in,
    input wire [7:0] rdata_out,
    input wire [3:0] general_input_pins_in,
    input wire [7:0] general_output_pins_out,
    input wire       baud_set_sel_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // Inputs must settle through the synchroniser before a read can report them
    sequence quiet_rd;
        $stable(general_input_pins_in) [*6] ##0 (rd_in && addr_in == 4'h4);
    endsequence
    sequence aux_wr;
        wr_in && addr_in == 4'h4;
    endsequence
    chk_set_pins_low: assert property (
        (wr_in && addr_in == 4'hE) ##1 !(wr_in && addr_in == 4'hF)
        |=> (general_output_pins_out & $past(wdata_in, 2)) == 8'h00) else $error("set missed");
    chk_clr_pins_high: assert property (
        (wr_in && addr_in == 4'hF) ##1 !(wr_in && addr_in == 4'hE) |=>
        (general_output_pins_out & $past(wdata_in, 2)) == $past(wdata_in, 2)) else $error("clr missed");
    chk_baud_follows: assert property (aux_wr ##1 !aux_wr
        |=> baud_set_sel_out == $past(wdata_in[7], 2)) else $error("baud select wrong");
    chk_baud_holds: assert property ($changed(baud_set_sel_out)
        |-> $past(wr_in && addr_in == 4'h4, 2)) else $error("baud select moved");
    chk_input_state: assert property (quiet_rd
        |=> rdata_out[3:0] == $past(general_input_pins_in)) else $error("input state wrong");
    chk_flags_clear: assert property (
        quiet_rd ##1 $stable(general_input_pins_in) [*2] ##0 (rd_in && addr_in == 4'h4)
        |=> rdata_out[7:4] == 4'h0) else $error("change flags kept");
    chk_latch_pins: assert property (rd_in && addr_in == 4'hC
        |=> general_output_pins_out == ~rdata_out) else $error("pins not inverse");
    chk_rdata_idle: assert property (!rd_in || addr_in < 4'h4
        |=> rdata_out == 8'h00) else $error("read data not zero");
endmodule

bind opac_port opac_port_assertions chk_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .general_input_pins_in(general_input_pins_in),
    .general_output_pins_out(general_output_pins_out), .baud_set_sel_out(baud_set_sel_out));

// ===== test/opac_host.sv
// Host model driving the register bus
`timescale 1ns/10ps
// ============================================================
// Host
module opac_host (
    input  wire       core_clk_in,
    output reg  [3:0] addr_out,
    output reg  [7:0] wdata_out,
    output reg        wr_out,
    output reg        rd_out,
    input  wire [7:0] rdata_in
);
    initial {addr_out, wdata_out, wr_out, rd_out} = 14'h0000;
    task wr(input [3:0] a, input [7:0] v);
        begin
            @(posedge core_clk_in);
            {addr_out, wdata_out, wr_out} <= {a, v, 1'b1};
            @(posedge core_clk_in);
            {wdata_out, wr_out} <= {~v, 1'b0};  // Stale data must not look valid
        end
    endtask
    task rd(input [3:0] a, output [7:0] v);
        begin
            @(posedge core_clk_in);
            {addr_out, rd_out} <= {a, 1'b1};
            @(posedge core_clk_in);
            rd_out <= 1'b0;
            #1 v = rdata_in;
        end
    endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the output port block
`timescale 1ns/10ps
`include "opac_defs.vh"
// ============================================================
// Bench
module tb_top;
    reg        core_clk_in;
    reg        nrst_in;
    reg        xtal;
    reg        prev;
    reg  [3:0] gip;
    reg  [7:0] d;
    reg  [7:0] lat;
    wire [3:0] addr;
    wire [7:0] wdata;
    wire       wr;
    wire       rd;
    wire [7:0] rdata;
    wire [7:0] pins;
    wire [7:0] oe;
    wire       ct;
    wire       baud;
    wire       irq_n;
    integer    err_total;
    integer    n_compared;
    integer    cyc;
    integer    i;
    integer    n;
    opac_host host_i (.core_clk_in(core_clk_in), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    opac_port opac_port_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .general_input_pins_in(gip), .chan_a_tx_bit_clock_in(1'b0),
        .chan_b_tx_bit_clock_in(1'b0), .crystal_clock_input_in(xtal),
        .other_status_in(7'h00), .alt_pin_src_in(6'h00), .general_output_pins_out(pins),
        .general_output_oe_out(oe), .baud_set_sel_out(baud), .ct_output_out(ct),
        .interrupt_out_n_out(irq_n));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial begin
        xtal = 1'b0;
        forever #20 xtal = ~xtal;
    end
    task chk(input [79:0] what, input [7:0] exp, input [7:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatched %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Ceiling well above the few thousand cycles the sequence needs
    always @(posedge core_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    initial begin
        {err_total, n_compared, cyc} = 0;
        {nrst_in, gip, lat} = 13'h0000;
        repeat (10) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        chk("pins", 8'hFF, pins);
        chk("oe", 8'hFF, oe);
        host_i.rd(4'h1, d);
        chk("unmapped", 8'h00, d);
        for (i = 0; i < 8; i = i + 1) begin
            host_i.wr(`OPAC_OFS_BIT_SETTER, 8'h01 << i);
            lat = lat | (8'h01 << i);
            host_i.rd(`OPAC_OFS_LATCH_VIEW, d);
            chk("latch", lat, d);
            chk("pins", ~lat, pins);
        end
        host_i.wr(`OPAC_OFS_BIT_CLEARER, 8'h5A);
        host_i.wr(`OPAC_OFS_BIT_SETTER, 8'h00);
        host_i.rd(`OPAC_OFS_LATCH_VIEW, d);
        chk("latch", 8'hA5, d);
        chk("pins", 8'h5A, pins);
        // Only input 0 may raise the input change status
        host_i.wr(`OPAC_OFS_AUX_CTRL, 8'h01);
        host_i.wr(`OPAC_OFS_INT_MASK, 8'h80);
        @(posedge core_clk_in) gip <= 4'h2;
        repeat (10) @(posedge core_clk_in);
        chk("irq_n", 8'h01, irq_n);
        host_i.rd(`OPAC_OFS_INT_STATUS, d);
        chk("isr7", 8'h00, d[7]);
        host_i.rd(`OPAC_OFS_IN_CHANGE, d);
        chk("input_change_register", 8'h22, d);
        @(posedge core_clk_in) gip <= 4'h3;
        repeat (10) @(posedge core_clk_in);
        chk("irq_n", 8'h00, irq_n);
        host_i.rd(`OPAC_OFS_IN_CHANGE, d);
        chk("input_change_register", 8'h13, d);
        host_i.rd(`OPAC_OFS_IN_CHANGE, d);
        chk("input_change_register_again", 8'h03, d);
        repeat (3) @(posedge core_clk_in);
        chk("irq_n", 8'h01, irq_n);
        host_i.wr(`OPAC_OFS_INT_MASK, 8'h00);
        @(posedge core_clk_in) gip <= 4'h2;
        repeat (10) @(posedge core_clk_in);
        chk("irq_n", 8'h01, irq_n);
        host_i.rd(`OPAC_OFS_INT_STATUS, d);
        chk("isr7", 8'h01, d[7]);
        host_i.rd(`OPAC_OFS_IN_CHANGE, d);
        host_i.rd(`OPAC_OFS_INT_STATUS, d);
        chk("isr7", 8'h00, d[7]);
        for (i = 0; i < 8; i = i + 1) begin
            host_i.wr(`OPAC_OFS_AUX_CTRL, ((i & 1) << 7) | (i << 4));
            repeat (2) @(posedge core_clk_in);
            chk("baud", i & 1, baud);
        end
        // Timer from the crystal clock toggles, a counter would stop once
        host_i.wr(`OPAC_OFS_AUX_CTRL, 8'h60);
        n = 0;
        prev = ct;
        repeat (400) begin
            @(posedge core_clk_in);
            #1 n = n + (ct !== prev);
            prev = ct;
        end
        chk("ct_edges", 8'h01, n >= 4);
        host_i.wr(`OPAC_OFS_AUX_CTRL, 8'h30);
        repeat (4) @(posedge core_clk_in);
        #1;
        chk("ct_start", 8'h01, ct);
        repeat (1500) @(posedge core_clk_in);
        #1;
        chk("ct_end", 8'h00, ct);
        host_i.rd(`OPAC_OFS_INT_STATUS, d);
        chk("isr3", 8'h01, d[3]);
        chk("oe", 8'hFF, oe);
        summarize;
    end
endmodule
